// >>> logic/irq_reset_cfg.svh
`ifndef IRQ_RESET_CFG_SVH
`define IRQ_RESET_CFG_SVH
// register addresses (five-bit field of the address byte)
`define ADDR_IRQ_MASK     5'h04
`define ADDR_IRQ_FLAGS    5'h05
`define ADDR_RESET_MASK   5'h06
`define ADDR_SYS_STATUS   5'h0C
// bit positions shared by the mask and flag registers
`define BIT_BUS_EDGE      5
`define BIT_OVERTEMP      4
`define BIT_UNDERVOLT     3
`define BIT_OVERVOLT      2
`define BIT_OVERCURRENT   1
// reset mask register bits
`define BIT_THERMAL_TEST  7
`define BIT_OV_RESET_EN   1
`define BIT_OT_RESET_EN   0
// system status register bits
`define BIT_SS_OUT_OC     5
`define BIT_SS_UV         3
`define BIT_SS_OV         2
`define BIT_SS_HB_OC      1
`define BIT_SS_OT         0
// reset values
`define IRQ_MASK_RESET    8'h00
`define IRQ_FLAGS_RESET   8'h00
`define RESET_MASK_RESET  8'h00
// frame length in sampling edges
`define FRAME_EDGES       16
// serial clock limit and core clock
`define SCK_MAX_MHZ       4
`define CORE_MHZ          250
`endif

// >>> logic/irq_reset_pkg.sv
package irq_reset_pkg;
  // decoded command of one finished frame
  typedef struct packed {
    logic       write;   // one for a write frame
    logic [4:0] addr;    // register address
    logic [7:0] data;    // write data byte
  } frame_cmd_t;
endpackage

// >>> logic/pin_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser with agreement of the last two stages
module pin_sync #(
  parameter int           WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output      logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q;  // metastable stage, read only by s2
  logic [WIDTH-1:0] s2_q;  // second stage
  logic [WIDTH-1:0] s3_q;  // third stage

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  // shift chain
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dout <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          dout[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

// >>> logic/spi_frame.sv
`timescale 1ns/1ps
`include "irq_reset_cfg.svh"
// serial slave: shifts out on sck rise, samples on sck fall
module spi_frame
  import irq_reset_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       sel_n,      // synchronised slave select
  input  wire logic       sck,        // synchronised serial clock
  input  wire logic       mosi,       // synchronised data in
  input  wire logic [7:0] status,     // system status byte
  input  wire logic [7:0] rdata,      // data of addressed register
  output      logic [4:0] rd_addr,    // address to read
  output      logic       miso,       // data out
  output      logic       miso_oe,    // low impedance while selected
  output      logic       cmd_valid,  // one-cycle pulse on accepted write
  output      frame_cmd_t cmd         // accepted command
);
  logic       sel_prev_q;  // select one cycle ago
  logic       sck_prev_q;  // clock one cycle ago
  logic [4:0] cnt_q;       // sampling edges seen, saturates at 31
  logic [15:0] rx_q;       // received bits
  logic [15:0] tx_q;       // bits to send
  logic       sel_fall;
  logic       sel_rise;
  logic       sck_rise;
  logic       sck_fall;
  logic       parity_ok;

  assign sel_fall = sel_prev_q && !sel_n;
  assign sel_rise = !sel_prev_q && sel_n;
  assign sck_rise = !sck_prev_q && sck && !sel_n;
  assign sck_fall = sck_prev_q && !sck && !sel_n;
  // the read address is used at the eighth falling edge, before that shift,
  // when the address bits still sit just above the unused bit
  assign rd_addr  = rx_q[5:1];
  // even parity over the write bit and address
  assign parity_ok = (^rx_q[15:10]) == rx_q[8];

  // edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_prev_q <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      sel_prev_q <= sel_n;
      sck_prev_q <= sck;
    end
  end

  // receive path and edge counting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 5'h00;
      rx_q  <= 16'h0000;
    end else if (sel_fall) begin
      cnt_q <= 5'h00;
    end else if (sck_fall) begin
      rx_q <= {rx_q[14:0], mosi};
      if (cnt_q != 5'h1F) begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // transmit path: status byte first, register byte loaded after 8 edges
  // register data is captured at the falling edge that samples the parity bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_q <= 16'h0000;
      miso <= 1'b0;
    end else if (sel_fall) begin
      tx_q <= {status, 8'h00};
    end else if (sck_fall && cnt_q == 5'h07) begin
      tx_q[15:8] <= rdata;
    end else if (sck_rise) begin
      miso <= tx_q[15];
      tx_q <= {tx_q[14:0], 1'b0};
    end
  end

  // output enable follows select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      miso_oe <= 1'b0;
    end else begin
      miso_oe <= !sel_n;
    end
  end

  // commit write at select rise if count and parity are right
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_valid <= 1'b0;
      cmd       <= '0;
    end else begin
      cmd_valid <= sel_rise && cnt_q == 5'(`FRAME_EDGES) && !rx_q[15]
                   && parity_ok;
      cmd.write <= !rx_q[15];
      cmd.addr  <= rx_q[14:10];
      cmd.data  <= rx_q[7:0];
    end
  end
endmodule

// >>> logic/irq_reset_ctrl.sv
`timescale 1ns/1ps
`include "irq_reset_cfg.svh"
// What this block does
// - all interrupt sources disabled after reset
// - undervoltage sets flag, gated interrupt
// - supply faults force high-side transistors off
// - overvoltage sets flag, gated interrupt
// - stop mode blocks voltage, temperature detection, except on the reset line
// - overtemperature sets flag, gated interrupt
// - bus falling edge interrupts, wakes in stop
// - any overcurrent sets flag, gated interrupt
// - only enabled wake events wake system
// - bus edge flag cleared by one only
// - condition flags ignore clear while present
// - overcurrent flag read-only, cleared via status
// - each enable gates its own flag
// - overtemperature reset only when enabled
// - logic supply low always pulls reset
// - overvoltage reset only when enabled
// - watchdog timeout pulls reset line
// - low reset line is external reset
// - test bit lowers thermal threshold
// - two-byte frames, serial clock up to 4 MHz
// - select starts frame; out rise, in fall
// - exactly sixteen sampling edges accepted
// - write commits at select rise; tristate
// - even parity checked on writes only
// - first returned byte is system status
// - open-drain active-low interrupt output
module irq_reset_ctrl
  import irq_reset_pkg::*;
(
  input  wire logic       CLOCK,
  input  wire logic       RSTN,
  input  wire logic       SEL_N,             // slave select pin
  input  wire logic       SERIAL_CLOCK_PIN,  // serial clock pin
  input  wire logic       MOSI,
  output      logic       MISO,
  output      logic       MISO_OE,
  input  wire logic       BUS_RX,            // bus receiver level
  input  wire logic       UNDERVOLT,         // supply below low threshold
  input  wire logic       OVERVOLT,          // supply above high threshold
  input  wire logic       OVERTEMP,          // chip above temperature threshold
  input  wire logic       HB_OVERCURRENT,    // any half-bridge overcurrent
  input  wire logic       OUT_OVERCURRENT,   // switched supply overcurrent
  input  wire logic       LOGIC_SUPPLY_LOW,  // logic supply below reset level
  input  wire logic       SUPPLY_HIGH,       // supply above reset level
  input  wire logic       WATCHDOG_TIMEOUT,  // autonomous watchdog expired
  input  wire logic       STOP_MODE,         // device in stop mode
  input  wire logic       RESET_IN,          // level of shared reset wire
  output      logic       IRQ_N_OUT,         // always low, drives with enable
  output      logic       IRQ_OE,            // high while pulling irq low
  output      logic       RESET_N_OUT,       // always low, drives with enable
  output      logic       RESET_OE,          // high while pulling reset low
  output      logic       EXT_RESET,         // external reset seen
  output      logic       HIGH_SIDE_OFF,     // force high-side transistors off
  output      logic       WAKEUP,            // wake micro and main regulator
  output      logic       THERMAL_TEST       // lowered thermal threshold
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers for pins
  ////////////////////////////////////////////////////////////////////////////

  localparam int IN_W = 14;  // number of asynchronous inputs
  logic [IN_W-1:0] raw;      // raw pin vector
  logic [IN_W-1:0] syn;      // filtered pin vector
  logic sel_n_s, sck_s, mosi_s, bus_s, uv_s, ov_s, ot_s;
  logic hb_oc_s, out_oc_s, lsl_s, sh_s, wd_s, stop_s, rst_pin_s;

  // serial clock must be slow enough for three-stage sampling
  initial begin
    if (`SCK_MAX_MHZ * 8 > `CORE_MHZ) $error("core clock too slow for serial clock");
  end

  assign raw = {SEL_N, SERIAL_CLOCK_PIN, MOSI, BUS_RX, UNDERVOLT, OVERVOLT,
                OVERTEMP, HB_OVERCURRENT, OUT_OVERCURRENT, LOGIC_SUPPLY_LOW,
                SUPPLY_HIGH, WATCHDOG_TIMEOUT, STOP_MODE, RESET_IN};
  assign {sel_n_s, sck_s, mosi_s, bus_s, uv_s, ov_s, ot_s, hb_oc_s,
          out_oc_s, lsl_s, sh_s, wd_s, stop_s, rst_pin_s} = syn;

  // idle levels: select high, bus recessive, reset wire high
  pin_sync #(
    .WIDTH (IN_W),
    .INIT  (14'h2401)
  ) u_sync (
    .clk   (CLOCK),
    .rst_n (RSTN),
    .din   (raw),
    .dout  (syn)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers
  ////////////////////////////////////////////////////////////////////////////

  logic [7:0] irq_mask_q;    // interrupt enable mask
  logic [7:0] reset_mask_q;  // reset source mask
  logic       bus_edge_flag_q;
  logic       overtemp_flag_q;
  logic       undervoltage_flag_q;
  logic       overvoltage_flag_q;
  logic       hb_oc_q;       // half-bridge overcurrent status
  logic       out_oc_q;      // switched output overcurrent status
  logic       bus_prev_q;    // bus level one cycle ago
  logic [7:0] irq_flags;     // flag register view
  logic [7:0] sys_status;    // system status view
  logic [7:0] rdata;         // read mux
  logic [4:0] rd_addr;
  logic       cmd_valid;
  frame_cmd_t cmd;
  logic       wr_mask, wr_flags, wr_rmask, wr_status;
  logic       bus_fall;
  logic       overcurrent_flag;
  logic       uv_det, ov_det, ot_det;
  logic [7:0] pending;

  // a mask bit decoded from an accepted write
  function automatic logic one_at(input logic [7:0] d, input int b);
    return d[b];
  endfunction

  assign wr_mask   = cmd_valid && cmd.addr == `ADDR_IRQ_MASK;
  assign wr_flags  = cmd_valid && cmd.addr == `ADDR_IRQ_FLAGS;
  assign wr_rmask  = cmd_valid && cmd.addr == `ADDR_RESET_MASK;
  assign wr_status = cmd_valid && cmd.addr == `ADDR_SYS_STATUS;
  assign bus_fall  = bus_prev_q && !bus_s;

  // detectors are blinded in stop mode
  assign uv_det = uv_s && !stop_s;
  assign ov_det = ov_s && !stop_s;
  assign ot_det = ot_s && !stop_s;

  // overcurrent flag formed from both status bits
  assign overcurrent_flag = hb_oc_q || out_oc_q;

  // flag register image, unused bits read zero
  always_comb begin
    irq_flags = 8'h00;
    irq_flags[`BIT_BUS_EDGE]    = bus_edge_flag_q;
    irq_flags[`BIT_OVERTEMP]    = overtemp_flag_q;
    irq_flags[`BIT_UNDERVOLT]   = undervoltage_flag_q;
    irq_flags[`BIT_OVERVOLT]    = overvoltage_flag_q;
    irq_flags[`BIT_OVERCURRENT] = overcurrent_flag;
  end

  // status image; only the bits this block owns are filled
  always_comb begin
    sys_status = 8'h00;
    sys_status[`BIT_SS_OUT_OC] = out_oc_q;
    sys_status[`BIT_SS_UV]     = undervoltage_flag_q;
    sys_status[`BIT_SS_OV]     = overvoltage_flag_q;
    sys_status[`BIT_SS_HB_OC]  = hb_oc_q;
    sys_status[`BIT_SS_OT]     = overtemp_flag_q;
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    unique case (rd_addr)
      `ADDR_IRQ_MASK:   rdata = irq_mask_q;
      `ADDR_IRQ_FLAGS:  rdata = irq_flags;
      `ADDR_RESET_MASK: rdata = reset_mask_q;
      `ADDR_SYS_STATUS: rdata = sys_status;
      default:          rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial slave
  ////////////////////////////////////////////////////////////////////////////

  logic miso_d, miso_oe_d;  // outputs of the frame engine

  spi_frame u_spi (
    .clk       (CLOCK),
    .rst_n     (RSTN),
    .sel_n     (sel_n_s),
    .sck       (sck_s),
    .mosi      (mosi_s),
    .status    (sys_status),
    .rdata     (rdata),
    .rd_addr   (rd_addr),
    .miso      (miso_d),
    .miso_oe   (miso_oe_d),
    .cmd_valid (cmd_valid),
    .cmd       (cmd)
  );

  // register the pin drivers so outputs come from flops
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      MISO    <= 1'b0;
      MISO_OE <= 1'b0;
    end else begin
      MISO    <= miso_d;
      MISO_OE <= miso_oe_d && !sel_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mask registers
  ////////////////////////////////////////////////////////////////////////////

  // interrupt mask: only the five enable bits are writable
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      irq_mask_q <= `IRQ_MASK_RESET;
    end else if (wr_mask) begin
      irq_mask_q <= cmd.data & 8'h3E;
    end
  end

  // reset mask: test bit and two reset enables
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      reset_mask_q <= `RESET_MASK_RESET;
    end else if (wr_rmask) begin
      reset_mask_q <= cmd.data & 8'h83;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags; a set in the same cycle as a clear wins
  ////////////////////////////////////////////////////////////////////////////

  // bus edge history
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      bus_prev_q <= 1'b1;
    end else begin
      bus_prev_q <= bus_s;
    end
  end

  // bus edge flag: one clears, zero has no effect
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      bus_edge_flag_q <= 1'b0;
    end else if (bus_fall) begin
      bus_edge_flag_q <= 1'b1;
    end else if (wr_flags && one_at(cmd.data, `BIT_BUS_EDGE)) begin
      bus_edge_flag_q <= 1'b0;
    end
  end

  // condition flags: a clear is refused while the condition holds
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      overtemp_flag_q     <= 1'b0;
      undervoltage_flag_q <= 1'b0;
      overvoltage_flag_q  <= 1'b0;
    end else begin
      if (ot_det) begin
        overtemp_flag_q <= 1'b1;
      end else if (wr_flags && one_at(cmd.data, `BIT_OVERTEMP)) begin
        overtemp_flag_q <= 1'b0;
      end
      if (uv_det) begin
        undervoltage_flag_q <= 1'b1;
      end else if (wr_flags && one_at(cmd.data, `BIT_UNDERVOLT)) begin
        undervoltage_flag_q <= 1'b0;
      end
      if (ov_det) begin
        overvoltage_flag_q <= 1'b1;
      end else if (wr_flags && one_at(cmd.data, `BIT_OVERVOLT)) begin
        overvoltage_flag_q <= 1'b0;
      end
    end
  end

  // overcurrent status bits, cleared only through the status register
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      hb_oc_q  <= 1'b0;
      out_oc_q <= 1'b0;
    end else begin
      if (hb_oc_s) begin
        hb_oc_q <= 1'b1;
      end else if (wr_status && one_at(cmd.data, `BIT_SS_HB_OC)) begin
        hb_oc_q <= 1'b0;
      end
      if (out_oc_s) begin
        out_oc_q <= 1'b1;
      end else if (wr_status && one_at(cmd.data, `BIT_SS_OUT_OC)) begin
        out_oc_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt, wake-up and protection outputs
  ////////////////////////////////////////////////////////////////////////////

  // each enable gates only its own flag
  assign pending = irq_flags & irq_mask_q;

  // open-drain interrupt, level while any pair is pending
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      IRQ_N_OUT <= 1'b0;
      IRQ_OE    <= 1'b0;
    end else begin
      IRQ_N_OUT <= 1'b0;
      IRQ_OE    <= |pending;
    end
  end

  // wake only on an enabled wake source while stopped
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      WAKEUP <= 1'b0;
    end else begin
      WAKEUP <= stop_s && pending[`BIT_BUS_EDGE];
    end
  end

  // high-side shutdown on either supply fault, low sides untouched
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      HIGH_SIDE_OFF <= 1'b0;
    end else begin
      HIGH_SIDE_OFF <= uv_det || ov_det;
    end
  end

  // test bit drives the thermal threshold select
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      THERMAL_TEST <= 1'b0;
    end else begin
      THERMAL_TEST <= reset_mask_q[`BIT_THERMAL_TEST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset line
  ////////////////////////////////////////////////////////////////////////////

  // logic supply low is unmaskable; watchdog always resets
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      RESET_N_OUT <= 1'b0;
      RESET_OE    <= 1'b0;
    end else begin
      RESET_N_OUT <= 1'b0;
      RESET_OE    <= lsl_s
                     || wd_s
                     || (sh_s && reset_mask_q[`BIT_OV_RESET_EN])
                     || (ot_s && reset_mask_q[`BIT_OT_RESET_EN]);
    end
  end

  logic [4:0] oe_hist_q;  // recent pull history, spans the pin sync delay

  // a low wire that we are not pulling is an external reset; our own release
  // needs a few cycles to reach the synced pin, so that span is waited out
  always_ff @(posedge CLOCK) begin
    if (!RSTN) begin
      oe_hist_q <= 5'h00;
      EXT_RESET <= 1'b0;
    end else begin
      oe_hist_q <= {oe_hist_q[3:0], RESET_OE};
      EXT_RESET <= !rst_pin_s && !RESET_OE && oe_hist_q == 5'h00;
    end
  end
endmodule

// >>> bench/irq_reset_ctrl_properties.sv
`timescale 1ns/1ps
// pin-level checks; inputs pass a sync chain, so eight cycles clears any latency
module irq_reset_ctrl_properties (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic SEL_N,
  input wire logic UNDERVOLT,
  input wire logic OVERTEMP,
  input wire logic LOGIC_SUPPLY_LOW,
  input wire logic SUPPLY_HIGH,
  input wire logic WATCHDOG_TIMEOUT,
  input wire logic STOP_MODE,
  input wire logic RESET_IN,
  input wire logic MISO_OE,
  input wire logic IRQ_N_OUT,
  input wire logic IRQ_OE,
  input wire logic RESET_N_OUT,
  input wire logic RESET_OE,
  input wire logic EXT_RESET,
  input wire logic HIGH_SIDE_OFF,
  input wire logic WAKEUP,
  input wire logic THERMAL_TEST
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  //////////////////////////////////////////////////////////////////////////////
  a_irq_after_reset: assert property ($rose(RSTN) |-> !IRQ_OE [*8])
    else $error("interrupt requested right after reset");
  a_highside_undervolt: assert property ((UNDERVOLT && !STOP_MODE) [*8] |-> HIGH_SIDE_OFF)
    else $error("high side left on during undervoltage");
  a_stop_no_wake: assert property ((!STOP_MODE) [*8] |-> !WAKEUP)
    else $error("wake outside stop mode");
  a_logic_low_reset: assert property (LOGIC_SUPPLY_LOW [*8] |-> RESET_OE)
    else $error("logic supply low without reset");
  a_watchdog_reset: assert property (WATCHDOG_TIMEOUT [*8] |-> RESET_OE)
    else $error("watchdog timeout without reset");
  a_reset_quiet: assert property ((!LOGIC_SUPPLY_LOW && !SUPPLY_HIGH && !WATCHDOG_TIMEOUT
    && !OVERTEMP) [*8] |-> !RESET_OE) else $error("reset pulled with no cause");
  a_ext_reset_seen: assert property ((!RESET_IN && !RESET_OE) [*8] |-> EXT_RESET)
    else $error("low reset wire not seen");
  a_test_bit_commit: assert property ($rose(THERMAL_TEST) |-> $past(SEL_N))
    else $error("test bit changed inside a frame");
  a_miso_released: assert property (SEL_N [*8] |-> !MISO_OE)
    else $error("data out driven while deselected");
  a_open_drain_low: assert property (!IRQ_N_OUT && !RESET_N_OUT)
    else $error("open-drain level not low");
  // main scenarios reached
  cover property ($rose(IRQ_OE));
  cover property ($rose(WAKEUP));
  cover property ($rose(RESET_OE));
endmodule
bind irq_reset_ctrl irq_reset_ctrl_properties u_irq_reset_ctrl_properties (
  .CLOCK(CLOCK), .RSTN(RSTN), .SEL_N(SEL_N), .UNDERVOLT(UNDERVOLT), .OVERTEMP(OVERTEMP),
  .LOGIC_SUPPLY_LOW(LOGIC_SUPPLY_LOW), .SUPPLY_HIGH(SUPPLY_HIGH),
  .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .STOP_MODE(STOP_MODE), .RESET_IN(RESET_IN),
  .MISO_OE(MISO_OE), .IRQ_N_OUT(IRQ_N_OUT), .IRQ_OE(IRQ_OE), .RESET_N_OUT(RESET_N_OUT),
  .RESET_OE(RESET_OE), .EXT_RESET(EXT_RESET), .HIGH_SIDE_OFF(HIGH_SIDE_OFF),
  .WAKEUP(WAKEUP), .THERMAL_TEST(THERMAL_TEST));

// >>> bench/spi_host_model.sv
`timescale 1ns/1ps
// host master of the register link; serial clock stands low between frames
module spi_host_model (
  input  wire logic clk,
  output      logic sel_n,
  output      logic sck,
  output      logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  logic seen_q; // last bit taken from the data out line
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    seen_q = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // one frame, msb first; edges other than 16 only when a refusal is wanted
  task automatic xfer(input logic [15:0] tx, input int edges, output logic [15:0] rx);
    rx = 16'h0000;
    sel_n = 1'b0;
    #62.5;
    for (int i = 0; i < edges; i++) begin
      sck = 1'b1;
      mosi = tx[15 - (i % 16)];
      #62.5;
      sck = 1'b0;
      // a released line must not show a stale value
      seen_q = miso_oe ? miso : ~seen_q;
      rx = {rx[14:0], seen_q};
      #62.5;
    end
    sel_n = 1'b1;
    mosi = ~mosi;
    repeat (12) @(posedge clk);
    #1;
  endtask
endmodule

// >>> bench/irq_reset_ctrl_tb.sv
`timescale 1ns/1ps
`include "irq_reset_cfg.svh"
module irq_reset_ctrl_tb;
  logic       clock, rstn, bus_rx, lsl, shi, wdt, stop, host_pull;
  logic [4:0] cond; // undervolt, overvolt, overtemp, bridge oc, output oc
  logic       sel_n, sck, mosi, miso, miso_oe, irq_n, irq_oe, rst_n_o, rst_oe;
  logic       ext_rst, hs_off, wake, thermal_threshold_test;
  logic [15:0] rx;
  int         fail_count, num_checks;
  logic [4:0] regs[4] = '{`ADDR_IRQ_MASK, `ADDR_IRQ_FLAGS, `ADDR_RESET_MASK, 5'h08};
  logic [7:0] fb[5] = '{8'h02, 8'h02, 8'h10, 8'h04, 8'h08}; // flag bit per condition
  wire        reset_wire = !(rst_oe || host_pull); // pulled-up shared wire
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  irq_reset_ctrl u_irq_reset_ctrl (.CLOCK(clock), .RSTN(rstn), .SEL_N(sel_n),
    .SERIAL_CLOCK_PIN(sck), .MOSI(mosi), .MISO(miso), .MISO_OE(miso_oe), .BUS_RX(bus_rx),
    .UNDERVOLT(cond[4]), .OVERVOLT(cond[3]), .OVERTEMP(cond[2]), .HB_OVERCURRENT(cond[1]),
    .OUT_OVERCURRENT(cond[0]), .LOGIC_SUPPLY_LOW(lsl), .SUPPLY_HIGH(shi),
    .WATCHDOG_TIMEOUT(wdt), .STOP_MODE(stop), .RESET_IN(reset_wire), .IRQ_N_OUT(irq_n),
    .IRQ_OE(irq_oe), .RESET_N_OUT(rst_n_o), .RESET_OE(rst_oe), .EXT_RESET(ext_rst),
    .HIGH_SIDE_OFF(hs_off), .WAKEUP(wake), .THERMAL_TEST(thermal_threshold_test));
  spi_host_model u_spi_host_model (.clk(clock), .sel_n(sel_n), .sck(sck), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe));
  //////////////////////////////////////////////////////////////////////////////
  // inputs set after w move one nanosecond after a rising edge; the host model times the serial pins itself
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [15:0] frm(input logic r, input logic [4:0] a, input logic [7:0] d,
                                      input logic bad);
    return {r, a, 1'b0, ^{r, a} ^ bad, d};
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_spi_host_model.xfer(frm(1'b0, a, d, 1'b0), 16, rx);
  endtask
  task automatic rd(input string n, input logic [4:0] a, input logic [7:0] e);
    u_spi_host_model.xfer(frm(1'b1, a, 8'h00, 1'b0), 16, rx);
    chk(n, {8'h00, e}, {8'h00, rx[7:0]});
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // a hang is cut well past the expected run of forty-four frames
  initial begin
    #300000;
    fail_count++;
    complete_run();
  end
  initial begin
    {rstn, lsl, shi, wdt, stop, host_pull, cond} = '0;
    bus_rx = 1'b1;
    w(4);
    rstn = 1'b1;
    w(8);
    chk("idle pins", 16'h0, {11'h0, irq_oe, rst_oe, thermal_threshold_test, irq_n, rst_n_o});
    foreach (regs[i]) rd("reset value", regs[i], 8'h00);
    cond[4] = 1'b1;
    w(20);
    chk("high side off", 16'h1, {15'h0, hs_off});
    u_spi_host_model.xfer(frm(1'b1, `ADDR_IRQ_FLAGS, 8'h00, 1'b0), 16, rx);
    chk("status and flags", 16'h0808, rx);
    chk("irq masked", 16'h0, {15'h0, irq_oe});
    wr(`ADDR_IRQ_MASK, 8'hFF);
    rd("mask", `ADDR_IRQ_MASK, 8'h3E);
    // each condition: clear refused while present or read-only, then a real clear
    for (int i = 4; i >= 0; i--) begin
      cond[i] = 1'b1;
      w(20);
      wr(`ADDR_IRQ_FLAGS, fb[i]);
      cond[i] = 1'b0;
      w(20);
      wr(`ADDR_IRQ_FLAGS, i > 1 ? 8'h00 : fb[i]);
      rd("flag held", `ADDR_IRQ_FLAGS, fb[i]);
      chk("irq level", 16'h1, {15'h0, irq_oe});
      if (i > 1) wr(`ADDR_IRQ_FLAGS, fb[i]);
      else wr(`ADDR_SYS_STATUS, i == 1 ? 8'h02 : 8'h20);
      rd("flag cleared", `ADDR_IRQ_FLAGS, 8'h00);
      chk("irq released", 16'h0, {15'h0, irq_oe});
    end
    // refused writes: bad parity, short and long frames; a read ignores parity
    u_spi_host_model.xfer(frm(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b1), 16, rx);
    // shifted so that a wrongly accepted short or long frame would clear the mask
    u_spi_host_model.xfer(frm(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b0) << 1, 15, rx);
    u_spi_host_model.xfer(frm(1'b0, `ADDR_IRQ_MASK, 8'h00, 1'b0) >> 1, 17, rx);
    u_spi_host_model.xfer(frm(1'b1, `ADDR_IRQ_MASK, 8'h00, 1'b1), 16, rx);
    chk("mask kept", 16'h3E, {8'h00, rx[7:0]});
    // stop mode: bus edge wakes, undervoltage is not detected
    stop = 1'b1;
    cond[4] = 1'b1;
    bus_rx = 1'b0;
    w(20);
    chk("wake", 16'h1, {15'h0, wake});
    rd("stop flags", `ADDR_IRQ_FLAGS, 8'h20);
    {bus_rx, cond[4]} = 2'b10;
    wr(`ADDR_IRQ_MASK, 8'h1E);
    chk("no wake", 16'h0, {15'h0, wake});
    stop = 1'b0;
    wr(`ADDR_IRQ_FLAGS, 8'h20);
    rd("bus flag cleared", `ADDR_IRQ_FLAGS, 8'h00);
    shi = 1'b1;
    w(20);
    chk("ov reset masked", 16'h0, {15'h0, rst_oe});
    wr(`ADDR_RESET_MASK, 8'hFF);
    rd("reset mask", `ADDR_RESET_MASK, 8'h83);
    chk("ov reset", 16'h3, {14'h0, rst_oe, thermal_threshold_test});
    shi = 1'b0;
    for (int i = 0; i < 3; i++) begin
      {wdt, lsl, cond[2]} = 3'b001 << i;
      w(20);
      chk("reset cause", 16'h1, {15'h0, rst_oe});
    end
    {wdt, lsl, cond[2]} = 3'b000;
    w(20);
    host_pull = 1'b1;
    w(20);
    chk("ext reset", 16'h1, {14'h0, rst_oe, ext_rst});
    host_pull = 1'b0;
    rstn = 1'b0;
    w(4);
    rstn = 1'b1;
    w(8);
    rd("reset mask cleared", `ADDR_RESET_MASK, 8'h00);
    rd("irq mask cleared", `ADDR_IRQ_MASK, 8'h00);
    complete_run();
  end
endmodule
